// ===== include/sipo_pkg.sv
package sipo_pkg;
    typedef struct packed {
        logic [2:0] shclk_sync;
        logic [2:0] latclk_sync;
        logic [1:0] clr_sync;
        logic [1:0] oe_sync;
        logic [1:0] din_sync;
        logic [7:0] shift;
        logic [7:0] store;
        logic dout;
        logic [7:0] drive;
    } sipo_state_type;
endpackage : sipo_pkg

// ===== include/sipo_regs.svh
`ifndef SIPO_REGS_SVH
`define SIPO_REGS_SVH
// stage count
`define SIPO_WIDTH 8
// every stage clears to zero
`define SIPO_RST_VAL 8'h00
// cascaded shift clock ceiling, in MHz, exceeded by the controller
`define SIPO_SHIFT_MAX_MHZ 5
`endif

// ===== tb/sipo_ctrl_model.sv
module sipo_ctrl_model (
    // system
    input wire logic clk,
    // pins toward the device
    output logic shift_clk,
    output logic latch_clk,
    output logic data,
    // cascade pin back from the device
    input wire logic cascade_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // 160 ns shift period (6.25 MHz), above the 5 MHz cascade ceiling
    localparam int HALF = 4;
    logic [7:0] got = 8'h00;
    initial begin
        shift_clk = 1'b0;
        latch_clk = 1'b0;
        data = 1'b0;
    end
    ////////////////////////////////////////
    // msb first; data moves only while the clock is low
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            shift_clk <= 1'b0;
            data <= b[i];
            repeat (HALF) @(posedge clk);
            shift_clk <= 1'b1;
            repeat (HALF) @(posedge clk);
            got <= {got[6:0], cascade_in};
        end
    endtask : send_byte
    task automatic pulse_latch();
        latch_clk <= 1'b1;
        repeat (HALF) @(posedge clk);
        latch_clk <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse_latch
endmodule : sipo_ctrl_model

// ===== tb/sipo_driver_tb.sv
module sipo_driver_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clear_all_n = 1'b1;
    logic out_enable_n = 1'b1;
    logic sclk, lclk, sdin, sdout;
    logic [7:0] sink_out, sink_oe_n, prev, b;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'hfa5caa09;
    always #10 clk = ~clk;
    sipo_driver i_sipo_driver (.clk(clk), .rst(rst), .serial_shift_clock(sclk),
        .latch_clock(lclk), .clear_all_n(clear_all_n), .out_enable_n(out_enable_n),
        .serial_input_pin(sdin), .serial_output_pin(sdout), .sink_out(sink_out),
        .sink_oe_n(sink_oe_n));
    sipo_ctrl_model i_sipo_ctrl_model (.clk(clk), .shift_clk(sclk), .latch_clk(lclk),
        .data(sdin), .cascade_in(sdout));
    ////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] exp_sinks(input logic [7:0] stored, input logic en_n,
        input logic clr_n);
        exp_sinks = (en_n || !clr_n) ? 8'hff : ~stored;
    endfunction : exp_sinks
    task automatic end_sim();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // guard against a hung handshake
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        prev = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        out_enable_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int n = 0; n < 8; n++) begin
            b = (n == 0) ? 8'hff : (n == 1) ? 8'h81 : (n == 2) ? 8'h00 : 8'($random(seed));
            i_sipo_ctrl_model.send_byte(b);
            i_sipo_ctrl_model.pulse_latch();
            check("cascade", i_sipo_ctrl_model.got, prev);
            check("sinks", sink_oe_n, exp_sinks(b, 1'b0, 1'b1));
            check("sink_out", sink_out, 8'h00);
            prev = b;
        end
        out_enable_n <= 1'b1;
        repeat (8) @(posedge clk);
        check("disabled", sink_oe_n, exp_sinks(prev, 1'b1, 1'b1));
        out_enable_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("reenabled", sink_oe_n, exp_sinks(prev, 1'b0, 1'b1));
        clear_all_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("cleared", sink_oe_n, exp_sinks(prev, 1'b0, 1'b0));
        check("cascade_clr", {7'h00, sdout}, 8'h00);
        clear_all_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("store_clr", sink_oe_n, exp_sinks(8'h00, 1'b0, 1'b1));
        i_sipo_ctrl_model.send_byte(8'h5a);
        // last cascade bit lands by nba on return, so read it later
        i_sipo_ctrl_model.pulse_latch();
        check("shift_clr", i_sipo_ctrl_model.got, 8'h00);
        check("relatch", sink_oe_n, exp_sinks(8'h5a, 1'b0, 1'b1));
        end_sim();
    end
endmodule : sipo_driver_tb

// ===== verilog/sipo_driver.sv
`include "sipo_regs.svh"
// Summary of operation
// - eight-stage shift register feeding storage register
// - shift clock rise shifts in serial bit
// - latch clock rise copies all stages
// - storage reaches outputs only while clear high
// - clear low zeroes shift and storage
// - enable low makes outputs follow storage
// - serial output updates on shift clock fall
// - buffer bit zero turns sink off
// - buffer bit one turns sink on
module sipo_driver (
    // system
    input wire logic clk,
    input wire logic rst,
    // control pins, asynchronous to clk
    input wire logic serial_shift_clock,
    input wire logic latch_clock,
    input wire logic clear_all_n,
    input wire logic out_enable_n,
    input wire logic serial_input_pin,
    // cascade output
    output logic serial_output_pin,
    // open-drain sinks: sink_oe_n low means pulled low (sinking)
    output logic [7:0] sink_out,
    output logic [7:0] sink_oe_n
);
    ////////////////////////////////////////////////////////////////////////
    sipo_pkg::sipo_state_type st_r;
    sipo_pkg::sipo_state_type st_nxt;
    logic sh_rise;
    logic sh_fall;
    logic lat_rise;
    logic clr_n;
    logic oe_n;

    // edges taken on synchronised copies only; stage 0 feeds stage 1 alone
    assign sh_rise = st_r.shclk_sync[1] & ~st_r.shclk_sync[2];
    assign sh_fall = ~st_r.shclk_sync[1] & st_r.shclk_sync[2];
    assign lat_rise = st_r.latclk_sync[1] & ~st_r.latclk_sync[2];
    assign clr_n = st_r.clr_sync[1];
    assign oe_n = st_r.oe_sync[1];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.shclk_sync = {st_r.shclk_sync[1:0], serial_shift_clock};
        st_nxt.latclk_sync = {st_r.latclk_sync[1:0], latch_clock};
        st_nxt.clr_sync = {st_r.clr_sync[0], clear_all_n};
        st_nxt.oe_sync = {st_r.oe_sync[0], out_enable_n};
        st_nxt.din_sync = {st_r.din_sync[0], serial_input_pin};
        if (!clr_n) begin
            st_nxt.shift = `SIPO_RST_VAL;
            st_nxt.store = `SIPO_RST_VAL;
        end else begin
            if (sh_rise) begin
                // data delayed as much as clock, so setup holds
                st_nxt.shift = {st_r.shift[6:0], st_r.din_sync[1]};
            end
            if (lat_rise) begin
                // old shift value on a coincident edge, as in the silicon
                st_nxt.store = st_r.shift;
            end
        end
        if (sh_fall) begin
            st_nxt.dout = st_r.shift[7];
        end
        if (!clr_n) begin
            st_nxt.dout = 1'b0;
        end
        if (oe_n || !clr_n) begin
            st_nxt.drive = `SIPO_RST_VAL;
        end else begin
            st_nxt.drive = st_r.store;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign serial_output_pin = st_r.dout;
    assign sink_out = 8'h00;
    assign sink_oe_n = ~st_r.drive;

    ////////////////////////////////////////////////////////////////////////
    AST_CLEAR_ZEROES: assert property (@(posedge clk) disable iff (rst)
        !clr_n |=> (st_r.shift == 8'h00 && st_r.store == 8'h00))
        else $error("clear did not zero registers");
    AST_SHIFT_IN: assert property (@(posedge clk) disable iff (rst)
        (clr_n && sh_rise) |=> st_r.shift == {$past(st_r.shift[6:0]), $past(st_r.din_sync[1])})
        else $error("shift did not advance");
    AST_SHIFT_HOLD: assert property (@(posedge clk) disable iff (rst)
        (clr_n && !sh_rise) |=> $stable(st_r.shift))
        else $error("shift moved without edge");
    AST_LATCH: assert property (@(posedge clk) disable iff (rst)
        (clr_n && lat_rise) |=> st_r.store == $past(st_r.shift))
        else $error("latch did not load");
    AST_DOUT_FALL: assert property (@(posedge clk) disable iff (rst)
        (clr_n && sh_fall) |=> serial_output_pin == $past(st_r.shift[7]))
        else $error("serial out not updated on fall");
    AST_DOUT_STABLE: assert property (@(posedge clk) disable iff (rst)
        (clr_n && !sh_fall) |=> $stable(serial_output_pin))
        else $error("serial out changed off fall");
    AST_OE_OFF: assert property (@(posedge clk) disable iff (rst)
        oe_n |=> sink_oe_n == 8'hff)
        else $error("sinks on while disabled");
    AST_FOLLOW: assert property (@(posedge clk) disable iff (rst)
        (!oe_n && clr_n) |=> sink_oe_n == ~$past(st_r.store))
        else $error("sinks not following storage");
    AST_CLR_OFF: assert property (@(posedge clk) disable iff (rst)
        !clr_n |=> sink_oe_n == 8'hff)
        else $error("sinks on during clear");

    ////////////////////////////////////////////////////////////////////////
    // pin to strobe latency: two sync stages, then the edge compare
    property p_rise_from_pin;
        @(posedge clk) disable iff (rst)
        sh_rise |-> ($past(serial_shift_clock, 2) && !$past(serial_shift_clock, 3));
    endproperty : p_rise_from_pin
    AST_RISE_FROM_PIN: assert property (p_rise_from_pin)
        else $error("shift rise strobe off its pin edge");

    property p_fall_from_pin;
        @(posedge clk) disable iff (rst)
        sh_fall |-> (!$past(serial_shift_clock, 2) && $past(serial_shift_clock, 3));
    endproperty : p_fall_from_pin
    AST_FALL_FROM_PIN: assert property (p_fall_from_pin)
        else $error("shift fall strobe off its pin edge");

    property p_latch_from_pin;
        @(posedge clk) disable iff (rst)
        lat_rise |-> ($past(latch_clock, 2) && !$past(latch_clock, 3));
    endproperty : p_latch_from_pin
    AST_LATCH_FROM_PIN: assert property (p_latch_from_pin)
        else $error("latch strobe off its pin edge");

    // data and clock must see equal delay, else setup is lost
    property p_din_aligned;
        @(posedge clk) disable iff (rst)
        (clr_n && sh_rise) |=> st_r.shift[0] == $past(serial_input_pin, 3);
    endproperty : p_din_aligned
    AST_DIN_ALIGNED: assert property (p_din_aligned)
        else $error("shifted bit not the one at the clock edge");

    property p_dout_last;
        @(posedge clk) disable iff (rst)
        (clr_n && sh_rise) |-> serial_output_pin == st_r.shift[7];
    endproperty : p_dout_last
    AST_DOUT_LAST: assert property (p_dout_last)
        else $error("serial out not the last stage");

    property p_dout_clear;
        @(posedge clk) disable iff (rst)
        !clr_n |=> !serial_output_pin;
    endproperty : p_dout_clear
    AST_DOUT_CLEAR: assert property (p_dout_clear)
        else $error("serial out not cleared");

    property p_clear_recover;
        @(posedge clk) disable iff (rst)
        !clr_n ##1 (clr_n && !oe_n) |=> sink_oe_n == 8'hff;
    endproperty : p_clear_recover
    AST_CLEAR_RECOVER: assert property (p_clear_recover)
        else $error("storage not zero after clear");

    property p_store_hold;
        @(posedge clk) disable iff (rst)
        (clr_n && !lat_rise) |=> $stable(st_r.store);
    endproperty : p_store_hold
    AST_STORE_HOLD: assert property (p_store_hold)
        else $error("storage moved without latch edge");

    property p_sink_path;
        @(posedge clk) disable iff (rst)
        (!oe_n && clr_n && lat_rise) ##1 (!oe_n && clr_n) |=> sink_oe_n == ~$past(st_r.shift, 2);
    endproperty : p_sink_path
    AST_SINK_PATH: assert property (p_sink_path)
        else $error("latched byte not at sinks");

    property p_drive_hold;
        @(posedge clk) disable iff (rst)
        (!oe_n && clr_n && !lat_rise) ##1 (!oe_n && clr_n) |=> $stable(sink_oe_n);
    endproperty : p_drive_hold
    AST_DRIVE_HOLD: assert property (p_drive_hold)
        else $error("sinks moved without latch edge");

    property p_sink_on_stored;
        @(posedge clk) disable iff (rst)
        (~sink_oe_n & ~$past(st_r.store)) == 8'h00;
    endproperty : p_sink_on_stored
    AST_SINK_ON_STORED: assert property (p_sink_on_stored)
        else $error("sink on for a zero storage bit");

    property p_sinks_gated;
        @(posedge clk) disable iff (rst)
        (sink_oe_n != 8'hff) |-> (!$past(oe_n) && $past(clr_n));
    endproperty : p_sinks_gated
    AST_SINKS_GATED: assert property (p_sinks_gated)
        else $error("sink on while disabled or cleared");

    COV_DISABLED: cover property (@(posedge clk) disable iff (rst) oe_n && st_r.store != 8'h00);
    COV_SHIFT: cover property (@(posedge clk) disable iff (rst) clr_n && sh_rise);
    COV_LATCH: cover property (@(posedge clk) disable iff (rst) clr_n && lat_rise);
    COV_SINK: cover property (@(posedge clk) disable iff (rst) sink_oe_n != 8'hff);
    COV_CLEAR: cover property (@(posedge clk) disable iff (rst) !clr_n ##1 clr_n);
endmodule : sipo_driver
